// ---- logic/swc_map.vh ----
// Register map, field positions, reset values and timing counts of the wake-up control block.
`ifndef SWC_MAP_VH
`define SWC_MAP_VH

// Register byte addresses on the AXI4-Lite slave.
`define SWC_ADDR_WAKE_CONTROL 4'h0
`define SWC_ADDR_WAKE_STATUS  4'h4
`define SWC_ADDR_SLEEP_CTRL   4'h8

// Fields of wake_control.
`define SWC_TIMER_EN_BIT      0
`define SWC_CAL_EN_BIT        1
`define SWC_HOST_WAKE_BIT     2
`define SWC_AUTO_ADC_BIT      3
`define SWC_EXT_EN_LSB        4
`define SWC_EXT_EDGE_LSB      8
`define SWC_EXT_POL_LSB       12
`define SWC_CTRL_RESET        32'h0000F000
`define SWC_CTRL_WMASK        32'h0000FFFF

// Fields of the wake status register.
`define SWC_EXT_STAT_LSB      0
`define SWC_CAL_STAT_BIT      4
`define SWC_TIMER_STAT_BIT    5
`define SWC_STATE_LSB         8
`define SWC_STAT_W1C_MASK     8'h3F

// Fields of the sleep control register.
`define SWC_SLP_HIB_BIT       0
`define SWC_SLP_DOZE_BIT      1
`define SWC_SLP_HIB_FAST_BIT  2
`define SWC_SLP_CORE_RET_BIT  6
`define SWC_SLP_PAD_KEEP_BIT  7

// Power states.
`define SWC_ST_RUN            2'h0
`define SWC_ST_HIB            2'h1
`define SWC_ST_DOZE           2'h2
`define SWC_ST_ADC            2'h3

// Edge detector tick periods in 100 MHz aclk cycles; aclk stands in for the crystal.
// Sized at the counter width so that no connection has to drop bits.
`define SWC_XTAL_DIV          16'h0080
`define SWC_HIB_SLOW_COUNT    16'hC350
`define SWC_HIB_FAST_COUNT    16'h0C35

// Resp codes.
`define SWC_RESP_OKAY         2'h0
`define SWC_RESP_SLVERR       2'h2

`endif

// ---- logic/swc_tick_gen.v ----
// Enable pulse generator that clocks the external wake edge detector.
`include "swc_map.vh"

module swc_tick_gen #(
   parameter [15:0] SLOW_COUNT = `SWC_HIB_SLOW_COUNT
)(
   // Clock and reset
   input  wire       aclk,
   input  wire       aresetn,
   // Rate selection: 0 crystal/128, 1 hibernate slow, 2 hibernate fast
   input  wire [1:0] rate_sel,
   // One-cycle enable for the detector
   output reg        tick
);

   localparam [15:0] FAST_COUNT = `SWC_HIB_FAST_COUNT;
   localparam [15:0] XTAL_COUNT = `SWC_XTAL_DIV;

   reg  [15:0] count;
   reg  [15:0] limit;

   always @*
   begin
      case (rate_sel)
         2'h1:    limit = SLOW_COUNT;
         2'h2:    limit = FAST_COUNT;
         default: limit = XTAL_COUNT;
      endcase
   end

   // A rate change may shorten one period; the detector tolerates this.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count <= 16'h0000;
         tick  <= 1'b0;
      end
      else if (count >= limit - 16'h0001)
      begin
         count <= 16'h0000;
         tick  <= 1'b1;
      end
      else
      begin
         count <= count + 16'h0001;
         tick  <= 1'b0;
      end
   end

endmodule // swc_tick_gen

// ---- logic/swc_wake_ctrl.v ----
// Sleep and wake-up control: wake sources, power state, autonomous ADC and host-wake pin.
//
// Notes on behaviour
// R01: Each of four wake inputs selects edge sense (1) or level sense (0).
// R02: Level sense wakes while enabled and the input equals its polarity bit.
// R03: For level sense, the pin must go inactive before status is cleared.
// R04: Edge sense wakes after an active edge; status clears at any time.
// R05: Wake pulses must last at least two edge detector clock periods.
// R06: Detector runs at 2kHz or 32kHz in hibernate, crystal/128 in doze.
// R07: Four enable bits; only enabled wake inputs may end hibernate or doze.
// R08: With no wake input enabled, software must enable a timer wake source.
// R09: Autonomous mode wakes only the ADC; processor stays halted unless ADC interrupts.
// R10: On ADC interrupt the processor clears autonomous mode and re-enters sleep.
// R11: Autonomous mode only in hibernate with core state retention set.
// R12: Pair autonomous mode with periodic calendar wake and a watchdog sleep timer.
// R13: Host-wake drives wake pin zero low while asleep, high on wake.
// R14: Host-wake overrides the shared general pin; clearing returns it to general use.
// R15: First enabling host-wake over a pin driven 0 takes it from 0 to 1.
// R16: Calendar compare ends low power only when its enable bit is 1.
// R17: Sleep timer compare ends low power only when its enable bit is 1.
// R18: After reset sense, enable, autonomous, host-wake and timer bits read 0.
// R19: Polarity 1 means high level or rising edge, 0 low level or falling.
// R20: Change a polarity bit only while that input is disabled.
// R21: All enabled wake sources merge into one request ending hibernate or doze.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`include "swc_map.vh"

module swc_wake_ctrl #(
   parameter [15:0] HIB_SLOW_COUNT = `SWC_HIB_SLOW_COUNT
)(
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // External wake pins (asynchronous)
   input  wire [3:0]  wake_pin_in,
   // Timer compare events from on-chip timers
   input  wire        calendar_compare,
   input  wire        sleep_timer_compare,
   // ADC handshake for autonomous sampling
   input  wire        adc_done,
   input  wire        adc_irq,
   output reg         adc_wake,
   // Processor and power state
   output reg         core_halt,
   output reg  [1:0]  power_state,
   // Shared general pin, general-purpose side and pad side
   input  wire        shared_general_pin_out,
   input  wire        shared_general_pin_oe,
   output reg         wake_pin_zero_out,
   output reg         wake_pin_zero_oe
);

   reg  [31:0] wake_control;
   reg  [3:0]  ext_wake_status;
   reg         cal_status;
   reg         timer_status;
   reg         hib_fast_clk;
   reg         core_state_retention;
   reg         pad_ring_power_keep;
   reg  [1:0]  next_state;

   // Write channel holding registers.
   reg         aw_held;
   reg         w_held;
   reg  [3:0]  aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;

   // Pin synchronisers and edge history.
   reg  [3:0]  pin_meta;
   reg  [3:0]  pin_sync;
   reg  [3:0]  pin_prev_active;

   wire [3:0]  ext_wake_enable;
   wire [3:0]  ext_wake_sense_mode;
   wire [3:0]  ext_wake_polarity;
   wire        host_wake;
   wire        auto_adc;
   wire        cal_wake_enable;
   wire        sleep_timer_wake_enable;
   wire [3:0]  ext_en_eff;
   wire [3:0]  pin_active;
   wire [3:0]  edge_hit;
   wire [3:0]  level_hit;
   wire [3:0]  ext_hit;
   wire        det_tick;
   wire [1:0]  rate_sel;
   wire        do_write;
   wire        wr_status;
   wire        wr_sleep;
   wire        enter_hib;
   wire        enter_doze;
   wire        auto_eff;
   wire        adc_start;
   wire        wake_req;
   wire [7:0]  status_clr;

   // Merge write data into a register under the byte strobes and a writable mask.
   function [31:0] merge_word;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0]  strb;
      input [31:0] wmask;
      integer      i;
      begin
         merge_word = old_val;
         for (i = 0; i < 32; i = i + 1)
            if (strb[i / 8] && wmask[i])
               merge_word[i] = new_val[i];
      end
   endfunction

   // True when the register address is one that the block decodes.
   function addr_mapped;
      input [3:0] addr;
      begin
         addr_mapped = (addr == `SWC_ADDR_WAKE_CONTROL) ||
                       (addr == `SWC_ADDR_WAKE_STATUS)  ||
                       (addr == `SWC_ADDR_SLEEP_CTRL);
      end
   endfunction

   assign ext_wake_enable         = wake_control[`SWC_EXT_EN_LSB +: 4];
   assign ext_wake_sense_mode     = wake_control[`SWC_EXT_EDGE_LSB +: 4];
   assign ext_wake_polarity       = wake_control[`SWC_EXT_POL_LSB +: 4];
   assign host_wake               = wake_control[`SWC_HOST_WAKE_BIT];
   assign auto_adc                = wake_control[`SWC_AUTO_ADC_BIT];
   assign cal_wake_enable         = wake_control[`SWC_CAL_EN_BIT];
   assign sleep_timer_wake_enable = wake_control[`SWC_TIMER_EN_BIT];

   // Pin zero is an output while host-wake owns it, so it cannot wake the block.
   assign ext_en_eff = ext_wake_enable & {3'b111, ~host_wake};            // [R07] [R14]

   // Write channel: each address and data beat is taken on its own.
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready  = ~w_held;
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_write      = aw_held & w_held & ~s_axi_bvalid;
   assign wr_status     = do_write && (aw_addr == `SWC_ADDR_WAKE_STATUS) && w_strb[0];
   assign wr_sleep      = do_write && (aw_addr == `SWC_ADDR_SLEEP_CTRL) && w_strb[0];
   assign enter_hib     = wr_sleep && w_data[`SWC_SLP_HIB_BIT];
   assign enter_doze    = wr_sleep && w_data[`SWC_SLP_DOZE_BIT] && !w_data[`SWC_SLP_HIB_BIT];
   assign status_clr    = wr_status ? (w_data[7:0] & `SWC_STAT_W1C_MASK) : 8'h00;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 4'h0;
         w_data       <= 32'h00000000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SWC_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && !aw_held)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_mapped(aw_addr) ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Control registers; all functions come up disabled with level sense.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wake_control         <= `SWC_CTRL_RESET;                          // [R18]
         hib_fast_clk         <= 1'b0;
         core_state_retention <= 1'b0;
         pad_ring_power_keep  <= 1'b0;
      end
      else if (do_write && aw_addr == `SWC_ADDR_WAKE_CONTROL)
         wake_control <= merge_word(wake_control, w_data, w_strb, `SWC_CTRL_WMASK);
      else if (wr_sleep)
      begin
         hib_fast_clk         <= w_data[`SWC_SLP_HIB_FAST_BIT];
         core_state_retention <= w_data[`SWC_SLP_CORE_RET_BIT];
         pad_ring_power_keep  <= w_data[`SWC_SLP_PAD_KEEP_BIT];
      end
   end

   // Read channel answers one cycle after the address is taken.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `SWC_RESP_OKAY;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= addr_mapped(s_axi_araddr) ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
         case (s_axi_araddr)
            `SWC_ADDR_WAKE_CONTROL:
               s_axi_rdata <= wake_control;
            `SWC_ADDR_WAKE_STATUS:
               s_axi_rdata <= {22'h0, power_state, 2'h0, timer_status,
                               cal_status, ext_wake_status};
            `SWC_ADDR_SLEEP_CTRL:
               s_axi_rdata <= {24'h000000, pad_ring_power_keep, core_state_retention,
                               3'h0, hib_fast_clk, 2'h0};
            default:
               s_axi_rdata <= 32'h00000000;
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Detector rate follows the power state: hibernate and ADC slow or fast, crystal/128 otherwise.
   assign rate_sel = (power_state == `SWC_ST_HIB || power_state == `SWC_ST_ADC) ?
                     (hib_fast_clk ? 2'h2 : 2'h1) : 2'h0;                   // [R06]

   swc_tick_gen #(
      .SLOW_COUNT (HIB_SLOW_COUNT)
   ) u_tick_gen (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .rate_sel (rate_sel),
      .tick     (det_tick)
   );

   // Pins cross into aclk through two flops before any logic looks at them.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_meta        <= 4'h0;
         pin_sync        <= 4'h0;
         pin_prev_active <= 4'h0;
      end
      else
      begin
         pin_meta <= wake_pin_in;
         pin_sync <= pin_meta;
         if (det_tick)
            pin_prev_active <= pin_active;                                 // [R05]
      end
   end

   // Polarity 1 selects high or rising, 0 selects low or falling.
   assign pin_active = ~(pin_sync ^ ext_wake_polarity);                    // [R19]
   // A pulse held two detector periods is seen inactive then active at two ticks.
   assign edge_hit   = {4{det_tick}} & pin_active & ~pin_prev_active;      // [R04] [R05]
   assign level_hit  = pin_active;                                         // [R02]
   assign ext_hit    = ext_en_eff &
                       ((ext_wake_sense_mode & edge_hit) |
                        (~ext_wake_sense_mode & level_hit));               // [R01] [R07]

   // Autonomous sampling needs hibernate with core retention, otherwise it is ignored.
   assign auto_eff  = auto_adc & core_state_retention;                     // [R11]
   assign adc_start = auto_eff && power_state == `SWC_ST_HIB &&
                      calendar_compare && cal_wake_enable;                 // [R09]

   // Status flags are sticky; a new event in the clearing cycle wins over the clear.
   // A level-sensed input keeps setting its flag until the pin is released.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ext_wake_status <= 4'h0;
         cal_status      <= 1'b0;
         timer_status    <= 1'b0;
      end
      else
      begin
         ext_wake_status <= (ext_wake_status & ~status_clr[3:0]) | ext_hit; // [R03] [R04]
         cal_status      <= (cal_status & ~status_clr[`SWC_CAL_STAT_BIT]) |
                            (calendar_compare & cal_wake_enable & ~adc_start); // [R16]
         timer_status    <= (timer_status & ~status_clr[`SWC_TIMER_STAT_BIT]) |
                            (sleep_timer_compare & sleep_timer_wake_enable); // [R17]
      end
   end

   // One request from every enabled source ends hibernate or doze.
   assign wake_req = |(ext_wake_status & ext_en_eff) |
                     (cal_status & cal_wake_enable) |
                     (timer_status & sleep_timer_wake_enable);             // [R21] [R16] [R17]

   always @*
   begin
      case (power_state)
         `SWC_ST_RUN:
            if (enter_hib)
               next_state = `SWC_ST_HIB;
            else if (enter_doze)
               next_state = `SWC_ST_DOZE;
            else
               next_state = `SWC_ST_RUN;
         `SWC_ST_HIB:
            if (wake_req)
               next_state = `SWC_ST_RUN;                                    // [R21]
            else if (adc_start)
               next_state = `SWC_ST_ADC;                                    // [R09]
            else
               next_state = `SWC_ST_HIB;
         `SWC_ST_DOZE:
            next_state = wake_req ? `SWC_ST_RUN : `SWC_ST_DOZE;             // [R21]
         `SWC_ST_ADC:
            // The ADC alone runs; the processor wakes on its interrupt or on a wake request.
            if (wake_req || adc_irq)
               next_state = `SWC_ST_RUN;                                    // [R09]
            else if (adc_done)
               next_state = `SWC_ST_HIB;                                    // [R09]
            else
               next_state = `SWC_ST_ADC;
         default:
            next_state = `SWC_ST_RUN;
      endcase
   end

   // Power state and the pins it drives are all registered.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         power_state       <= `SWC_ST_RUN;
         core_halt         <= 1'b0;
         adc_wake          <= 1'b0;
         wake_pin_zero_out <= 1'b0;
         wake_pin_zero_oe  <= 1'b0;
      end
      else
      begin
         power_state <= next_state;
         core_halt   <= (next_state != `SWC_ST_RUN);                        // [R09]
         adc_wake    <= (next_state == `SWC_ST_ADC);                        // [R09]
         if (host_wake)
         begin
            // Awake drives 1, so a pin left at 0 by general use steps to 1 here.
            wake_pin_zero_oe  <= 1'b1;                                      // [R14]
            wake_pin_zero_out <= (next_state == `SWC_ST_RUN);               // [R13] [R15]
         end
         else
         begin
            wake_pin_zero_oe  <= shared_general_pin_oe;                     // [R14]
            wake_pin_zero_out <= shared_general_pin_out;
         end
      end
   end

endmodule // swc_wake_ctrl

// ---- dv/swc_far_model.sv ----
// Behavioural far side: wake pins, timer compare events and the ADC handshake.
module swc_far_model #(
   parameter int MIN_HOLD = 300
)(
   // Requests from the bench
   input  wire logic       aclk,
   input  wire logic [3:0] pin_goal,
   input  wire logic [3:0] go,
   // Far side signals
   output logic [3:0]      wake_pin_in = 4'h0,
   output logic            calendar_compare = 1'b0,
   output logic            sleep_timer_compare = 1'b0,
   output logic            adc_done = 1'b0,
   output logic            adc_irq = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int         hold [4] = '{default: 0};
   logic [3:0] go_q = 4'h0;
   // A pin level is held long enough to span two crystal/128 detector ticks.
   always @(posedge aclk)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (hold[i] < MIN_HOLD)
            hold[i] <= hold[i] + 1;
         else if (pin_goal[i] != wake_pin_in[i])
         begin
            wake_pin_in[i] <= pin_goal[i];
            hold[i] <= 0;
         end
      end
      go_q <= go;
      {calendar_compare, sleep_timer_compare, adc_done, adc_irq} <= go & ~go_q;
   end
endmodule // swc_far_model

// ---- dv/swc_wake_ctrl_chk.sv ----
// Concurrent checks of the wake-up control block, bound to its top module.
module swc_wake_chk #(
   parameter [15:0] HIB_SLOW_COUNT = 16'hC350
)(
   // Clock and reset
   input wire        aclk,
   input wire        aresetn,
   // Register bus
   input wire [3:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // Wake events and state
   input wire        calendar_compare,
   input wire        sleep_timer_compare,
   input wire        adc_wake,
   input wire        core_halt,
   input wire [1:0]  power_state,
   // Shared pin
   input wire        shared_general_pin_out,
   input wire        shared_general_pin_oe,
   input wire        wake_pin_zero_out,
   input wire        wake_pin_zero_oe
);
   logic [3:0]  aw_a;
   logic [3:0]  ctl;
   logic [31:0] wd;
   // The mirror lags the real register, so checks using it wait for bvalid to drop.
   always @(posedge aclk)
   begin
      if (!aresetn)
         ctl <= 4'h0;
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
            aw_a <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
            wd <= s_axi_wdata;
         if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0 && aw_a == 4'h0)
            ctl <= wd[3:0];
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
   endsequence
   sequence s_cal;
      calendar_compare && ctl[1] && power_state == 2'h2 && !s_axi_bvalid;
   endsequence
   sequence s_tmr;
      sleep_timer_compare && ctl[0] && power_state[0] != power_state[1] && !s_axi_bvalid;
   endsequence
   property p_wr;
      s_wr |-> ##[1:2] s_axi_bvalid;
   endproperty
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_rd;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_halt;
      core_halt == (power_state != 2'h0) && adc_wake == (power_state == 2'h3);
   endproperty
   property p_cal;
      s_cal |-> ##[1:4] power_state == 2'h0;
   endproperty
   property p_tmr;
      s_tmr |-> ##[1:4] power_state == 2'h0;
   endproperty
   property p_hw;
      ctl[2] && !s_axi_bvalid |-> wake_pin_zero_oe && wake_pin_zero_out == (power_state == 2'h0);
   endproperty
   property p_gp;
      !ctl[2] && !s_axi_bvalid && $stable(shared_general_pin_out) && $stable(shared_general_pin_oe)
         |-> wake_pin_zero_out == shared_general_pin_out && wake_pin_zero_oe == shared_general_pin_oe;
   endproperty
   a_wr: assert property (p_wr) else $error("write response late");
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   a_rd: assert property (p_rd) else $error("read data late");
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   a_halt: assert property (p_halt) else $error("halt or adc wake wrong");
   a_cal: assert property (p_cal) else $error("calendar wake missed");
   a_tmr: assert property (p_tmr) else $error("timer wake missed");
   a_hw: assert property (p_hw) else $error("host wake pin wrong");
   a_gp: assert property (p_gp) else $error("general pin not passed");
endmodule // swc_wake_chk

bind swc_wake_ctrl swc_wake_chk #(.HIB_SLOW_COUNT(HIB_SLOW_COUNT)) u_chk (.*);

// ---- dv/testbench.sv ----
// Self-checking bench of the wake-up control block.
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, goal = 4'h0, go = 4'h0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        gp_out = 0, gp_oe = 0;
   logic [31:0] wdata = 32'h0, rd, v;
   logic [1:0]  rs;
   wire         awready, wready, bvalid, arready, rvalid, cal, tmr, adone, airq;
   wire         adc_wake, halt, pz_out, pz_oe;
   wire [1:0]   bresp, rresp, ps;
   wire [31:0]  rdata;
   wire [3:0]   pins;
   int          n_mismatch = 0, total_checks = 0, cyc = 0;
   integer      seed = 32'h20950882;
   // Case table: control word, idle pins, source, wake expected, status expected.
   // Every word keeps some wake source enabled, so no sleep is entered without one.
   logic [15:0] t_ctl [9] = '{16'hF002, 16'hF001, 16'hF001, 16'hF002, 16'hF010, 16'hF001,
                              16'h7880, 16'h7840, 16'hF440};
   logic [3:0]  t_idl [9] = '{0, 0, 0, 0, 0, 0, 8, 0, 0};
   int          t_src [9] = '{0, 0, 1, 1, 4, 4, 7, 7, 6};
   logic        t_wk [9] = '{1, 0, 1, 0, 1, 0, 1, 0, 1};
   logic [5:0]  t_st [9] = '{6'h10, 0, 6'h20, 0, 6'h01, 0, 6'h08, 0, 6'h04};
   swc_wake_ctrl #(.HIB_SLOW_COUNT(16'h0010)) u_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .wake_pin_in(pins), .calendar_compare(cal), .sleep_timer_compare(tmr),
      .adc_done(adone), .adc_irq(airq), .adc_wake(adc_wake), .core_halt(halt),
      .power_state(ps), .shared_general_pin_out(gp_out), .shared_general_pin_oe(gp_oe),
      .wake_pin_zero_out(pz_out), .wake_pin_zero_oe(pz_oe));
   swc_far_model u_far (.aclk(aclk), .pin_goal(goal), .go(go), .wake_pin_in(pins),
      .calendar_compare(cal), .sleep_timer_compare(tmr), .adc_done(adone), .adc_irq(airq));
   always #5 aclk = ~aclk;
   task automatic wrap_up();
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_mismatch++;
         wrap_up();
      end
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic aw_d, w_d;
      aw_d = 0;
      w_d = 0;
      @(posedge aclk);
      awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; bready <= 1;
      while (!(aw_d && w_d))
      begin
         @(posedge aclk);
         if (!aw_d && awready) begin aw_d = 1; awvalid <= 0; end
         if (!w_d && wready) begin w_d = 1; wvalid <= 0; end
      end
      do @(posedge aclk); while (!bvalid);
      rs = bresp;
      bready <= 0;
   endtask
   task automatic rdr(input logic [3:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      rd = rdata; rs = rresp;
      rready <= 0;
   endtask
   // Pulses one far-side event: 0 calendar, 1 timer, 2 sample done, 3 ADC interrupt.
   task automatic fire(input int k);
      @(posedge aclk);
      go <= 4'h8 >> k;
      @(posedge aclk);
      go <= 4'h0;
   endtask
   task automatic wait_ps(input logic [1:0] s, input int lim);
      for (int n = 0; n < lim && ps !== s; n++)
         @(posedge aclk);
      #1;
   endtask
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      rdr(4'h0); `CHK("ctrl_reset", 32'h0000F000, rd)
      rdr(4'h4); `CHK("stat_reset", 32'h0, rd)
      repeat (8)
      begin
         v = $random(seed);
         wr(4'h0, v);
         gp_out <= v[20]; gp_oe <= v[21];
         rdr(4'h0); `CHK("ctrl_rw", v & 32'h0000FFFF, rd)
      end
      wr(4'hC, v); `CHK("wr_unmapped", 2'h2, rs)
      rdr(4'hC); `CHK("rd_unmapped", 2'h2, rs)
      for (int i = 0; i < 9; i++)
      begin
         wr(4'h0, {16'h0, t_ctl[i] & 16'hFF0F});
         goal <= t_idl[i];
         repeat (700) @(posedge aclk);
         wr(4'h0, {16'h0, t_ctl[i]});
         wr(4'h4, 32'h3F);
         wr(4'h8, 32'h2);
         wait_ps(2'h2, 10); `CHK("doze", 2'h2, ps)
         if (t_src[i] < 2)
            fire(t_src[i]);
         else
         begin
            @(posedge aclk) goal <= t_idl[i] ^ (4'h1 << (t_src[i] - 4));
            repeat (400) @(posedge aclk);
            goal <= t_idl[i];
         end
         wait_ps(2'h0, 700); `CHK("woke", t_wk[i], ps === 2'h0)
         if (t_wk[i])
         begin
            rdr(4'h4); `CHK("stat_src", t_st[i], rd[5:0])
            repeat (400) @(posedge aclk);
            wr(4'h4, 32'h3F);
            rdr(4'h4); `CHK("stat_clr", 6'h0, rd[5:0])
         end
         else
         begin
            wr(4'h0, 32'h0000F001);
            fire(1);
            wait_ps(2'h0, 10); `CHK("timer_exit", 2'h0, ps)
         end
      end
      wr(4'h0, 32'h0000F00B);
      wr(4'h4, 32'h3F);
      wr(4'h8, 32'hC5);
      wait_ps(2'h1, 10); `CHK("hib", 2'h1, ps)
      rdr(4'h8); `CHK("sleep_ctl", 32'hC4, rd)
      fire(0);
      wait_ps(2'h3, 10); `CHK("adc_run", 3'h7, {ps, adc_wake & halt})
      fire(2);
      wait_ps(2'h1, 10); `CHK("adc_back", 2'h1, ps)
      fire(0);
      wait_ps(2'h3, 10);
      fire(3);
      wait_ps(2'h0, 10); `CHK("adc_irq", 3'h0, {ps, halt})
      wr(4'h0, 32'h0000F001);
      gp_out <= 0; gp_oe <= 1;
      wr(4'h0, 32'h0000F005);
      repeat (2) @(posedge aclk);
      #1 `CHK("host_on", 2'h3, {pz_out, pz_oe})
      wr(4'h4, 32'h3F);
      wr(4'h8, 32'h2);
      wait_ps(2'h2, 10); `CHK("host_sleep", 2'h1, {pz_out, pz_oe})
      fire(1);
      wait_ps(2'h0, 10); `CHK("host_wake", 2'h3, {pz_out, pz_oe})
      wr(4'h0, 32'h0000F001);
      gp_out <= 1; gp_oe <= 0;
      repeat (3) @(posedge aclk);
      #1 `CHK("host_off", 2'h2, {pz_out, pz_oe})
      wrap_up();
   end
endmodule // testbench
